/* shared/lcd_cmd_defs.svh */
// Constants of the display RAM command decoder: codes, limits, reset values.
// Assumes one 25 MHz clock and a host bus presented as synchronous strobes.
`ifndef LCD_CMD_DEFS_SVH
`define LCD_CMD_DEFS_SVH
`define OP_PAGE 4'hb
`define OP_COL_HI 4'h1
`define OP_COL_LO 4'h0
`define OP_SEG 7'h50
`define OP_BIAS 7'h51
`define OP_ALLON 7'h52
`define OP_REVV 7'h53
`define OP_DISP 7'h57
`define OP_RMW 8'he0
`define OP_END 8'hee
`define OP_SRST 8'he2
`define PAGE_LAST 4'hc
`define COL_LAST 8'h83
`define RAM_COLS 11'h084
`define RAM_DEPTH 1716
`define RST_BUSY_CYC 3'h4
`define FIFO_FULL 2'h2
`endif

/* shared/lcd_cmd_pkg.sv */
// Types shared by the display RAM command decoder.
// Assumes the constants header is included by the users of these types.
package lcd_cmd_pkg;
  // One host bus cycle: register select, direction and write byte.
  typedef struct packed {
    logic cmd_data_select;
    logic rd;
    logic [7:0] wdata;
  } bus_req_t;

  // State of the decoder apart from the display RAM.
  typedef struct packed {
    bus_req_t [1:0] slot;
    logic [1:0] cnt;
    logic ready;
    logic [3:0] page;
    logic [7:0] col;
    logic [7:0] col_saved;
    logic rmw;
    logic [7:0] latch;
    logic seg_rev;
    logic disp_on;
    logic rev_video;
    logic all_on;
    logic bias_ninth;
    logic power_save;
    logic [2:0] rst_cnt;
    logic [7:0] rdata;
    logic rvalid;
  } dec_state_t;
endpackage

/* core/lcd_ram_access_command_decoder.sv */
// Command decoder and display RAM access path of a dot-matrix LCD driver.
// Assumes host strobes are synchronous one-cycle pulses on ref_clk.
// Assumes the host waits for an answer before it trusts data_out, since the
// read byte stands only until the next answer replaces it.
`timescale 1ns/100ps
`include "lcd_cmd_defs.svh"
module lcd_ram_access_command_decoder
  import lcd_cmd_pkg::*;
(
  // Clock and hardware reset pin.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Host bus request side.
  input wire logic req_valid,
  input wire logic cmd_data_select,
  input wire logic req_rd,
  input wire logic [7:0] data_in,
  input wire logic serial_mode,
  output logic req_ready,
  // Host bus read answer, data pins driven while data_oe is high.
  output logic [7:0] data_out,
  output logic data_oe,
  // Display control state.
  output logic seg_reverse,
  output logic display_on,
  output logic reverse_video,
  output logic all_dots_on,
  output logic bias_ninth,
  output logic power_save,
  output logic rmw_active
);

  dec_state_t st_q;
  dec_state_t st_d;
  // The RAM sits outside the state struct because it is far too large to be
  // cleared by either reset, and clearing it is not wanted anyway.
  // Eight vertically stacked dots per byte, one byte per page and column.
  logic [7:0] ram [0:`RAM_DEPTH-1];
  bus_req_t hd;
  logic exec;
  logic is_cmd;
  logic data_wr;
  logic data_rd;
  logic in_range;
  logic [10:0] ram_idx;
  logic ram_we;
  logic [7:0] ram_rd;
  logic [7:0] col_next;

  // Head of the buffer and its address into the display RAM.
  // Only the head is ever decoded, so commands and data accesses take effect
  // strictly in the order the host offered them.
  // The product is formed at eleven bits, which covers the whole RAM depth.
  assign hd = st_q.slot[0];
  assign is_cmd = !hd.cmd_data_select && !hd.rd;
  assign data_wr = hd.cmd_data_select && !hd.rd;
  assign data_rd = hd.cmd_data_select && hd.rd;
  assign in_range = (st_q.page <= `PAGE_LAST) && (st_q.col <= `COL_LAST);
  assign ram_idx = 11'(st_q.page) * `RAM_COLS + 11'(st_q.col);
  // Status reads drain even during reset so busy can be polled.
  assign exec = (st_q.cnt != 2'h0) &&
    ((st_q.rst_cnt == 3'h0) || (!hd.cmd_data_select && hd.rd));
  assign ram_we = exec && data_wr && in_range;
  assign ram_rd = in_range ? ram[ram_idx] : 8'h00;
  // Advance saturates at the last column.
  assign col_next = (st_q.col < `COL_LAST) ? st_q.col + 8'h01 : st_q.col;

  // Next state: buffer, command decode, data access and reset timer.
  always_comb begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    if (st_q.rst_cnt != 3'h0) begin
      st_d.rst_cnt = st_q.rst_cnt - 3'h1;
    end
    // Pop the head and shift; a new request fills the first free slot.
    // Ready is computed from the count after this cycle's push and pop, so a
    // registered ready never promises room that is not there.
    if (exec) begin
      st_d.slot[0] = st_q.slot[1];
      st_d.cnt = st_q.cnt - 2'h1;
    end
    if (req_valid && st_q.ready) begin
      if (st_d.cnt == 2'h0) begin
        st_d.slot[0] = '{cmd_data_select, req_rd, data_in};
      end else begin
        st_d.slot[1] = '{cmd_data_select, req_rd, data_in};
      end
      st_d.cnt = st_d.cnt + 2'h1;
    end
    st_d.ready = (st_d.cnt != `FIFO_FULL);
    // Nibble-coded commands are matched first; the longer codes all start
    // with an upper nibble of A or E and so never collide with them.
    if (exec && is_cmd) begin
      // Page select takes the low nibble as it stands.
      if (hd.wdata[7:4] == `OP_PAGE) begin
        st_d.page = hd.wdata[3:0];
      // Each column nibble takes effect alone, in either order.
      end else if (hd.wdata[7:4] == `OP_COL_HI) begin
        st_d.col[7:4] = hd.wdata[3:0];
      // Low nibble of the column address.
      end else if (hd.wdata[7:4] == `OP_COL_LO) begin
        st_d.col[3:0] = hd.wdata[3:0];
      // Segment order keeps the command bit as written.
      end else if (hd.wdata[7:1] == `OP_SEG) begin
        st_d.seg_rev = hd.wdata[0];
      // Reverse video only changes the dot sense, never the RAM.
      end else if (hd.wdata[7:1] == `OP_REVV) begin
        st_d.rev_video = hd.wdata[0];
      // All-on looks at the display state that is current before this command.
      end else if (hd.wdata[7:1] == `OP_ALLON) begin
        st_d.all_on = hd.wdata[0];
        st_d.power_save = hd.wdata[0] && !st_q.disp_on;
      // Bias one means the ninth ratio, zero the eleventh.
      end else if (hd.wdata[7:1] == `OP_BIAS) begin
        st_d.bias_ninth = hd.wdata[0];
      // Switching the display on always leaves power save.
      end else if (hd.wdata[7:1] == `OP_DISP) begin
        st_d.disp_on = hd.wdata[0];
        if (hd.wdata[0]) begin
          st_d.power_save = 1'b0;
        end
      // Entering again overwrites the saved column with the current one.
      end else if (hd.wdata == `OP_RMW) begin
        st_d.rmw = 1'b1;
        st_d.col_saved = st_q.col;
      // End outside the mode leaves the column where it is.
      end else if (hd.wdata == `OP_END) begin
        if (st_q.rmw) begin
          st_d.col = st_q.col_saved;
        end
        st_d.rmw = 1'b0;
      // Soft reset starts the same busy timer as the pin.
      end else if (hd.wdata == `OP_SRST) begin
        // Display RAM is left as it is.
        st_d.col = 8'h00;
        st_d.page = 4'h0;
        st_d.rmw = 1'b0;
        st_d.rst_cnt = `RST_BUSY_CYC;
      end
    end
    if (exec && !hd.cmd_data_select && hd.rd) begin
      // Busy and reset share the timer; the direction and display flags read
      // opposite to the command bits that set them.
      st_d.rdata = {st_q.rst_cnt != 3'h0, !st_q.seg_rev, !st_q.disp_on,
                    st_q.rst_cnt != 3'h0, 4'h0};
      st_d.rvalid = 1'b1;
    end
    if (exec && data_wr) begin
      st_d.col = col_next;
    end
    // The answer is the previous latch, so the first read after an
    // address change is a dummy. Serial hosts get no answer to a data read.
    if (exec && data_rd && !serial_mode) begin
      st_d.rdata = st_q.latch;
      st_d.rvalid = 1'b1;
      st_d.latch = ram_rd;
      if (!st_q.rmw) begin
        st_d.col = col_next;
      end
    end
  end

  // State register; hardware reset loads every default.
  // All-zero is the documented default for every control, so only the busy
  // timer needs a value of its own.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.rst_cnt <= `RST_BUSY_CYC;
    end else begin
      st_q <= st_d;
    end
  end

  // The RAM has no reset, so neither reset form disturbs it.
  // Writes out of range are dropped before they reach this port.
  always_ff @(posedge ref_clk) begin
    if (ram_we) begin
      ram[ram_idx] <= hd.wdata;
    end
  end

  // Outputs come straight from the state register.
  // No output is decoded, so none can glitch between edges.
  assign req_ready = st_q.ready;
  assign data_out = st_q.rdata;
  assign data_oe = st_q.rvalid;
  assign seg_reverse = st_q.seg_rev;
  assign display_on = st_q.disp_on;
  // All-on wins over reverse video at the dot decision downstream.
  assign reverse_video = st_q.rev_video;
  assign all_dots_on = st_q.all_on;
  assign bias_ninth = st_q.bias_ninth;
  assign power_save = st_q.power_save;
  assign rmw_active = st_q.rmw;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_cmd(logic [7:0] code);
    exec && is_cmd && hd.wdata == code;
  endsequence
  sequence s_status;
    exec && !hd.cmd_data_select && hd.rd;
  endsequence
  // Back-to-back reads may keep the answer pulse high, so only its start is named.
  sequence s_answer;
    ##1 data_oe;
  endsequence
  sequence s_data_wr;
    exec && data_wr;
  endsequence
  sequence s_data_rd;
    exec && data_rd && !serial_mode;
  endsequence
  sequence s_serial_rd;
    exec && data_rd && serial_mode;
  endsequence

  page_load_a: assert property (exec && is_cmd && hd.wdata[7:4] == `OP_PAGE |=> st_q.page == $past(hd.wdata[3:0]))
    else $error("page not loaded");
  col_stop_a: assert property (exec && data_wr && st_q.col == `COL_LAST |=> st_q.col == `COL_LAST)
    else $error("column ran past last");
  col_step_a: assert property (exec && data_wr && st_q.col < `COL_LAST |=> st_q.col == $past(st_q.col) + 8'h01)
    else $error("column did not advance on write");
  status_bits_a: assert property (s_status |-> s_answer and (##1 data_out[6] == !$past(st_q.seg_rev) && data_out[3:0] == 4'h0))
    else $error("status direction or low bits wrong");
  display_flag_a: assert property (s_status |=> data_out[5] == !$past(st_q.disp_on))
    else $error("display flag not inverted");
  rmw_hold_a: assert property (st_q.rmw && exec && data_rd && !serial_mode |=> st_q.col == $past(st_q.col))
    else $error("column moved on read in rmw");
  end_restore_a: assert property (s_cmd(`OP_END) and st_q.rmw |=> st_q.col == $past(st_q.col_saved) && !st_q.rmw)
    else $error("end did not restore column");
  soft_reset_a: assert property (s_cmd(`OP_SRST) |=> st_q.col == 8'h00 && st_q.page == 4'h0 && !st_q.rmw && st_q.rst_cnt != 3'h0)
    else $error("soft reset incomplete");
  serial_read_a: assert property (exec && data_rd && serial_mode |=> !data_oe)
    else $error("data read answered in serial mode");
  power_save_a: assert property (s_cmd(8'ha5) and !st_q.disp_on |=> power_save)
    else $error("power save not entered");

  // Every command lands in the control it names, one cycle after it executes.
  // The display controls are checked on the outputs and the column nibbles on the state register.
  // Column nibbles are checked apart, since each stands alone.
  col_hi_a: assert property (exec && is_cmd && hd.wdata[7:4] == `OP_COL_HI |=>
    st_q.col[7:4] == $past(hd.wdata[3:0]))
    else $error("upper column nibble not loaded");
  col_lo_a: assert property (exec && is_cmd && hd.wdata[7:4] == `OP_COL_LO |=>
    st_q.col[3:0] == $past(hd.wdata[3:0]))
    else $error("lower column nibble not loaded");
  seg_cmd_a: assert property (exec && is_cmd && hd.wdata[7:1] == `OP_SEG |=>
    seg_reverse == $past(hd.wdata[0]))
    else $error("segment order not taken");
  revv_cmd_a: assert property (exec && is_cmd && hd.wdata[7:1] == `OP_REVV |=>
    reverse_video == $past(hd.wdata[0]))
    else $error("reverse video not taken");
  allon_cmd_a: assert property (exec && is_cmd && hd.wdata[7:1] == `OP_ALLON |=>
    all_dots_on == $past(hd.wdata[0]))
    else $error("all-on not taken");
  bias_cmd_a: assert property (exec && is_cmd && hd.wdata[7:1] == `OP_BIAS |=>
    bias_ninth == $past(hd.wdata[0]))
    else $error("bias not taken");
  disp_cmd_a: assert property (exec && is_cmd && hd.wdata[7:1] == `OP_DISP |=>
    display_on == $past(hd.wdata[0]))
    else $error("display switch not taken");
  allon_keep_a: assert property (exec && is_cmd && hd.wdata[7:1] == `OP_REVV |=>
    all_dots_on == $past(all_dots_on))
    else $error("reverse video disturbed all-on");
  power_clear_a: assert property (s_cmd({`OP_DISP, 1'b1}) |=>
    !power_save)
    else $error("power save kept with display on");
  allon_ps_off_a: assert property (s_cmd({`OP_ALLON, 1'b0}) |=>
    !power_save)
    else $error("power save kept after all-on off");

  // Read-modify-write and End.
  rmw_enter_a: assert property (s_cmd(`OP_RMW) |=>
    st_q.rmw && st_q.col_saved == $past(st_q.col))
    else $error("rmw entry did not save column");
  col_rmw_cmd_a: assert property (s_cmd(`OP_RMW) |=>
    st_q.col == $past(st_q.col))
    else $error("rmw entry moved column");
  rmw_write_a: assert property (s_data_wr ##0 (st_q.rmw && st_q.col < `COL_LAST) |=>
    st_q.col == $past(st_q.col) + 8'h01)
    else $error("write in rmw did not advance column");
  end_plain_a: assert property (s_cmd(`OP_END) and !st_q.rmw |=>
    st_q.col == $past(st_q.col) && !st_q.rmw)
    else $error("end outside rmw moved column");

  // Data path: answers, column steps and range handling.
  read_answer_a: assert property (s_data_rd |=>
    data_oe && data_out == $past(st_q.latch))
    else $error("data read answer wrong");
  read_step_a: assert property (s_data_rd ##0 (!st_q.rmw && st_q.col < `COL_LAST) |=>
    st_q.col == $past(st_q.col) + 8'h01)
    else $error("column did not advance on read");
  read_stop_a: assert property (s_data_rd ##0 st_q.col == `COL_LAST |=>
    st_q.col == `COL_LAST)
    else $error("column ran past last on read");
  serial_hold_a: assert property (s_serial_rd |=>
    st_q.col == $past(st_q.col) && st_q.latch == $past(st_q.latch))
    else $error("serial read moved column or latch");
  oe_source_a: assert property (data_oe |->
    $past(exec && hd.rd && !(hd.cmd_data_select && serial_mode)))
    else $error("answer without a matching read");
  ram_write_a: assert property (ram_we |=>
    ram[$past(ram_idx)] == $past(hd.wdata))
    else $error("data write did not land");
  page_hold_data_a: assert property (s_data_wr |=>
    st_q.page == $past(st_q.page))
    else $error("data write moved page");
  drop_oor_a: assert property (s_data_wr ##0 !in_range |->
    !ram_we)
    else $error("out of range write reached RAM");
  range_read_a: assert property (s_data_rd ##0 !in_range |=>
    st_q.latch == 8'h00)
    else $error("out of range read latched data");

  // Status, reset timer and buffer.
  busy_flag_a: assert property (s_status |=>
    data_out[7] == ($past(st_q.rst_cnt) != 3'h0) && data_out[4] == data_out[7])
    else $error("busy or reset flag wrong");
  status_low_a: assert property (s_status |=>
    data_out[3:0] == 4'h0)
    else $error("status low bits not zero");
  status_quiet_a: assert property (s_status |=>
    st_q.col == $past(st_q.col) && st_q.page == $past(st_q.page))
    else $error("status read moved address");
  timer_step_a: assert property (st_q.rst_cnt != 3'h0 |=>
    st_q.rst_cnt == $past(st_q.rst_cnt) - 3'h1)
    else $error("reset timer did not count down");
  srst_ram_a: assert property (s_cmd(`OP_SRST) |->
    !ram_we)
    else $error("soft reset wrote RAM");
  srst_keep_a: assert property (s_cmd(`OP_SRST) |=>
    seg_reverse == $past(seg_reverse) && display_on == $past(display_on) && bias_ninth == $past(bias_ninth))
    else $error("soft reset changed display controls");
  ready_full_a: assert property (st_q.cnt == `FIFO_FULL |->
    !req_ready)
    else $error("ready shown with full buffer");
endmodule

/* verif/lcd_host_model.sv */
// Host model: offers bus cycles to the decoder and collects read answers.
// Assumes the decoder's registered ready and its one-cycle answer pulse.
`timescale 1ns/100ps
module lcd_host_model (
  // Clock and answers from the decoder.
  input wire logic ref_clk,
  input wire logic req_ready,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  // Request lines toward the decoder.
  output logic req_valid = 1'b0,
  output logic cmd_data_select = 1'b0,
  output logic req_rd = 1'b0,
  output logic [7:0] data_in = 8'h00
);
  // Holds a request until ready is seen at an edge; the idle bus then shows the inverse byte.
  task automatic put(input logic cds, input logic rd, input logic [7:0] d);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    cmd_data_select <= cds;
    req_rd <= rd;
    data_in <= d;
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    data_in <= ~d;
  endtask

  // Waits a bounded time for the answer pulse, which lasts one cycle only.
  task automatic get(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    repeat (12) begin
      @(negedge ref_clk);
      if (!ok && data_oe === 1'b1) begin
        ok = 1'b1;
        d = data_out;
      end
    end
  endtask
endmodule

/* verif/testbench.sv */
// Self-checking bench of the command decoder, driven through the host model.
// Assumes the constants header and the package are compiled first.
`timescale 1ns/100ps
`include "lcd_cmd_defs.svh"
module testbench;
  logic ref_clk, rst_n, serial_mode, req_valid, cmd_data_select, req_rd, req_ready, data_oe, ok;
  logic seg_reverse, display_on, reverse_video, all_dots_on, bias_ninth, power_save, rmw_active;
  logic [7:0] data_in, data_out, rb;
  int fails, tests_run, cyc;

  // Decoder and host model share every bus line by name except serial_mode, which the bench drives itself.
  lcd_ram_access_command_decoder DUT (.ref_clk, .rst_n, .req_valid, .cmd_data_select, .req_rd,
    .data_in, .serial_mode, .req_ready, .data_out, .data_oe, .seg_reverse, .display_on,
    .reverse_video, .all_dots_on, .bias_ninth, .power_save, .rmw_active);
  lcd_host_model host (.ref_clk, .req_ready, .data_out, .data_oe, .req_valid, .cmd_data_select,
    .req_rd, .data_in);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    host.put(1'b0, 1'b0, c);
  endtask
  task automatic wr(input logic [7:0] d);
    host.put(1'b1, 1'b0, d);
  endtask
  task automatic rd(input logic a, output logic [7:0] d);
    host.put(a, 1'b1, 8'h00);
    host.get(d, ok);
  endtask
  task automatic at(input logic [3:0] p, input logic [7:0] c);
    cmd({`OP_PAGE, p});
    cmd({`OP_COL_HI, c[7:4]});
    cmd({`OP_COL_LO, c[3:0]});
  endtask
  // Packs the control outputs so one compare covers them all.
  function automatic logic [7:0] ctl();
    return {1'b0, seg_reverse, display_on, bias_ninth, reverse_video, all_dots_on, power_save, rmw_active};
  endfunction

  task automatic t_reset();
    rd(1'b0, rb);
    chk(rb, 8'hf0);
    rd(1'b0, rb);
    chk(rb, 8'h60);
    chk(ctl(), 8'h00);
  endtask
  task automatic t_ctrl();
    cmd({`OP_SEG, 1'b1});
    cmd({`OP_DISP, 1'b1});
    cmd({`OP_BIAS, 1'b1});
    cmd({`OP_REVV, 1'b1});
    cmd({`OP_ALLON, 1'b1});
    rd(1'b0, rb);
    chk(rb, 8'h00);
    chk(ctl(), 8'h7c);
    cmd({`OP_DISP, 1'b0});
    cmd({`OP_ALLON, 1'b1});
    rd(1'b0, rb);
    chk(ctl(), 8'h5e);
    cmd({`OP_SEG, 1'b0});
    cmd({`OP_BIAS, 1'b0});
    cmd({`OP_REVV, 1'b0});
    cmd({`OP_ALLON, 1'b0});
    rd(1'b0, rb);
    chk(rb, 8'h60);
    chk(ctl(), 8'h00);
  endtask
  // Last-column writes pile onto column 131, since the address stops there.
  task automatic t_data();
    at(4'h2, 8'h82);
    wr(8'ha5);
    wr(8'h5a);
    wr(8'h3c);
    at(4'h2, 8'h82);
    rd(1'b1, rb);
    rd(1'b1, rb);
    chk(rb, 8'ha5);
    rd(1'b1, rb);
    chk(rb, 8'h3c);
  endtask
  task automatic t_rmw();
    at(4'h2, 8'h10);
    wr(8'h11);
    at(4'h2, 8'h10);
    cmd(`OP_RMW);
    rd(1'b1, rb);
    rd(1'b1, rb);
    chk(rb, 8'h11);
    chk(ctl(), 8'h01);
    wr(8'h22);
    cmd(`OP_END);
    rd(1'b1, rb);
    rd(1'b1, rb);
    chk(rb, 8'h22);
    chk(ctl(), 8'h00);
  endtask
  task automatic t_soft();
    at(4'h0, 8'h00);
    wr(8'h77);
    at(4'h3, 8'h40);
    cmd(`OP_RMW);
    cmd(`OP_SRST);
    rd(1'b0, rb);
    chk(rb & 8'h90, 8'h90);
    rd(1'b1, rb);
    rd(1'b1, rb);
    chk(rb, 8'h77);
    chk(ctl(), 8'h00);
  endtask
  task automatic t_serial();
    @(posedge ref_clk);
    serial_mode <= 1'b1;
    rd(1'b1, rb);
    chk({7'h0, ok}, 8'h00);
    @(posedge ref_clk);
    serial_mode <= 1'b0;
  endtask
  // A pin reset in mid-run must bring back every default and the busy window.
  task automatic t_hwrst();
    cmd({`OP_DISP, 1'b1});
    cmd({`OP_SEG, 1'b1});
    cmd({`OP_BIAS, 1'b1});
    rd(1'b0, rb);
    chk(rb, 8'h00);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(1'b0, rb);
    chk(rb, 8'hf0);
    chk(ctl(), 8'h00);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // A hang is cut short well past the few hundred cycles the tests need.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    serial_mode = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_ctrl();
    t_data();
    t_rmw();
    t_soft();
    t_serial();
    t_hwrst();
    stop_test();
  end
endmodule
